// *** design/io_port_block.sv ***
`timescale 1ns/10ps
module io_port_block
	import io_port_pkg::*;
#(
	parameter int PIN_COUNT = NUM_PINS
) (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire host_bus_s bus_i,
	input wire logic data_port_i,
	input wire pin_cfg_s [NUM_PINS-1:0] pin_cfg_i,
	input wire logic [NUM_PINS-1:0] pin_in_i,
	input wire logic [NUM_PINS-1:0] pt_oe_i,
	input wire logic [NUM_PINS-1:0] macro_i,
	input wire logic [2:0] ecs_i,
	input wire logic [5:0] imc_pt_i,
	output logic [NUM_PINS-1:0] pin_out_o,
	output logic [NUM_PINS-1:0] pin_oe_n_o,
	output logic [7:0] rdata_o,
	output logic rdata_oe_n_o,
	output logic [IMC_PINS-1:0] imc_out_o
);

	// the pin map below is fixed at 8+8+8+3
	if (PIN_COUNT != NUM_PINS) begin : g_bad_pins
		$error("io_port_block supports exactly 27 pins");
	end

	// every pin needs a port, and the last port must hold at least one pin
	if (NUM_PORTS * 8 < NUM_PINS || NUM_PINS <= (NUM_PORTS - 1) * 8) begin : g_bad_ports
		$error("io_port_block pins do not fill four ports");
	end

	// input macrocells sit on whole eight-pin ports only
	if (IMC_PINS % 8 != 0 || IMC_PINS >= NUM_PINS) begin : g_bad_imc
		$error("io_port_block macrocell count does not match the ports");
	end

	// one clock term per nibble; the term input is six bits wide
	if (IMC_PINS / 4 != 6) begin : g_bad_terms
		$error("io_port_block needs one clock term per nibble");
	end

	// control registers exist on the leading ports only
	if (int'(CTL_PORTS) > NUM_PORTS) begin : g_bad_ctl
		$error("io_port_block has more control ports than ports");
	end

	// address-out takes eight latched bits, offsets take the low byte
	if (HOST_ADDR_W < 8) begin : g_bad_addr
		$error("io_port_block needs at least eight address bits");
	end

	// two-flop synchronisers for every pin-level input; the third stage on the bus
	// and port a lets the write edge see address and data from the same sample
	// no reset here: reset is held long enough to flush every stage
	host_bus_s bus_s1, bus_s2, bus_d;
	logic [NUM_PINS-1:0] pin_s1, pin_s2;
	logic [7:0] pa_d;

	always_ff @(posedge ref_clk_i) begin
		bus_s1 <= bus_i;
		bus_s2 <= bus_s1;
		bus_d <= bus_s2;
		pin_s1 <= pin_in_i;
		pin_s2 <= pin_s1;
		pa_d <= pin_s2[7:0];
	end

	// write completes on the rising edge of the write strobe
	// select is taken from the older stage, so it may drop together with the strobe
	logic wr_end;
	logic [7:0] wdata;
	logic [7:0] waddr;
	logic rd_act;

	assign wr_end = bus_s2.wr_n & ~bus_d.wr_n & bus_d.sel;
	// the offset is the low address byte only; the high address bits are not decoded for writes
	assign waddr = bus_d.addr[7:0];
	// in data port mode the first port carries the host data bus
	// port a comes through its own synchroniser, aligned with the delayed bus stage
	assign wdata = data_port_i ? pa_d : bus_d.data;
	assign rd_act = ~bus_s2.rd_n & bus_s2.sel;

	// host-visible port registers
	logic [7:0] dout_reg [NUM_PORTS];
	logic [7:0] dir_reg [NUM_PORTS];
	logic [7:0] ctl_reg [NUM_PORTS];
	logic [7:0] dout_next [NUM_PORTS];
	logic [7:0] dir_next [NUM_PORTS];
	logic [7:0] ctl_next [NUM_PORTS];

	// register writes; each port has its own slot at a fixed offset
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			dout_next[p] = dout_reg[p];
			dir_next[p] = dir_reg[p];
			ctl_next[p] = ctl_reg[p];
			if (wr_end) begin
				if (waddr == OFS_DOUT[p]) begin
					dout_next[p] = wdata & PORT_MASK[p];
				end
				if (waddr == OFS_DIR[p]) begin
					dir_next[p] = wdata & PORT_MASK[p];
				end
				// only the first two ports own a control register
				if (waddr == OFS_CTL[p] && p < int'(CTL_PORTS)) begin
					ctl_next[p] = wdata;
				end
			end
		end
	end

	// registers reset to zero: direction bits clear, so only array outputs and enable terms drive in host I/O mode
	always_ff @(posedge ref_clk_i) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (!resetn_i) begin
				dout_reg[p] <= DOUT_RST;
				dir_reg[p] <= DIR_RST;
				ctl_reg[p] <= CTL_RST;
			end else begin
				dout_reg[p] <= dout_next[p];
				dir_reg[p] <= dir_next[p];
				ctl_reg[p] <= ctl_next[p];
			end
		end
	end

	// address latch follows the host address while the strobe is high
	// both address-out ports show bits seven to zero of this latch
	logic [HOST_ADDR_W-1:0] lat_reg, lat_next;

	always_comb begin
		lat_next = lat_reg;
		if (bus_s2.ale) begin
			lat_next = bus_s2.addr;
		end
	end

	// latch starts at zero so address-out pins come up low
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			lat_reg <= '0;
		end else begin
			lat_reg <= lat_next;
		end
	end

	// input macrocells, first three ports only
	logic [IMC_PINS-1:0] imc_reg, imc_next;
	logic [IMC_PINS-1:0] imc_en_reg, imc_en_next;
	wire [NUM_PINS-1:0] out_next;
	wire [NUM_PINS-1:0] oe_n_next;

	// readback mux; offsets are unique, so exactly one source reaches the bus
	// unmapped offsets and the missing control and macrocell slots read as zero
	logic [7:0] rd_next;
	logic [7:0] ofs;
	logic [7:0] din_p [NUM_PORTS];
	logic [7:0] imc_p [NUM_PORTS];
	logic [7:0] omc_p [NUM_PORTS];

	// gather pins into port bytes; the short port and absent macrocells read zero
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			din_p[p] = 8'h00;
			imc_p[p] = 8'h00;
			omc_p[p] = 8'h00;
			for (int b = 0; b < 8; b++) begin
				if (p * 8 + b < NUM_PINS) begin
					din_p[p][b] = pin_s2[p*8+b];
					omc_p[p][b] = macro_i[p*8+b];
				end
				if (p * 8 + b < IMC_PINS) begin
					imc_p[p][b] = imc_reg[p*8+b];
				end
			end
		end
	end

	always_comb begin
		ofs = bus_s2.addr[7:0];
		rd_next = UNMAPPED_READ;
		for (int p = NUM_PORTS - 1; p >= 0; p--) begin
			if (ofs == OFS_DIN[p]) begin
				rd_next = din_p[p];
			end else if (ofs == OFS_DOUT[p]) begin
				rd_next = dout_reg[p];
			end else if (ofs == OFS_DIR[p]) begin
				rd_next = dir_reg[p];
			end else if (ofs == OFS_CTL[p] && p < int'(CTL_PORTS)) begin
				rd_next = ctl_reg[p];
			end else if (ofs == OFS_IMC[p] && p < NUM_PORTS - 1) begin
				rd_next = imc_p[p];
			end else if (ofs == OFS_OMC[p]) begin
				rd_next = omc_p[p];
			end
		end
	end

	// per-pin output mux, driver enable and input macrocell
	for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
		localparam int P = i / 8;
		localparam int B = i % 8;
		logic addr_bit;
		logic ctl_bit;
		logic mux;
		logic drive;

		assign addr_bit = lat_reg[B];
		assign ctl_bit = (P < int'(CTL_PORTS)) ? ctl_reg[P][B] : 1'b0;

		// control bit forces address-out, otherwise stored source applies
		// ports c and d have no control bit, so their selection is fixed
		always_comb begin
			if (ctl_bit) begin
				mux = addr_bit;
			end else begin
				case (pin_cfg_i[i].src)
					SRC_DOUT: mux = dout_reg[P][B];
					SRC_ADDR: mux = addr_bit;
					SRC_MACRO: mux = macro_i[i];
					SRC_ECS: mux = ecs_i[i%3];
					default: mux = dout_reg[P][B];
				endcase
			end
		end

		// array outputs with no enable equation are driven from reset on, except on port a in data port mode
		// an enable term only ever adds to the direction bit, never masks it
		always_comb begin
			if (pin_cfg_i[i].has_oe) begin
				drive = pt_oe_i[i] | dir_reg[P][B];
			end else if (pin_cfg_i[i].la_out) begin
				drive = 1'b1;
			end else begin
				drive = dir_reg[P][B];
			end
		end

		if (P == 0) begin : g_dp
			// data port mode overrides general I/O on the first port
			assign out_next[i] = data_port_i ? rd_next[B] : mux;
			assign oe_n_next[i] = data_port_i ? ~rd_act : ~drive;
		end else begin : g_io
			assign out_next[i] = mux;
			assign oe_n_next[i] = ~drive;
		end

		if (i < IMC_PINS) begin : g_imc
			logic en;
			// one product term clocks each nibble, else the address strobe
			// register mode needs the previous enable; it resets low, so an enable already high at reset release counts as an edge
			assign en = pin_cfg_i[i].imc_clk_pt ? imc_pt_i[i/4] : bus_s2.ale;
			assign imc_en_next[i] = en;
			always_comb begin
				case (pin_cfg_i[i].imc_mode)
					IMC_DIRECT: imc_next[i] = pin_s2[i];
					IMC_LATCH: imc_next[i] = en ? pin_s2[i] : imc_reg[i];
					IMC_REG: imc_next[i] = (en & ~imc_en_reg[i]) ? pin_s2[i] : imc_reg[i];
					default: imc_next[i] = pin_s2[i];
				endcase
			end
		end
	end

	// high address bits latched in macrocells reach the logic array here
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			imc_reg <= '0;
			imc_en_reg <= '0;
		end else begin
			imc_reg <= imc_next;
			imc_en_reg <= imc_en_next;
		end
	end

	// the read data bus is driven only for a page read outside data port mode
	logic rdata_oe_n_next;

	always_comb begin
		rdata_oe_n_next = ~(rd_act & ~data_port_i);
	end

	// outputs leave from flops; one cycle behind the mux, well inside bus timing
	// the extra cycle costs nothing: the strobes are slow next to this clock
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			pin_out_o <= '0;
			pin_oe_n_o <= '1; // all pins float during reset
			rdata_o <= 8'h00;
			rdata_oe_n_o <= 1'b1;
			imc_out_o <= '0;
		end else begin
			pin_out_o <= out_next;
			pin_oe_n_o <= oe_n_next;
			rdata_o <= rd_next;
			rdata_oe_n_o <= rdata_oe_n_next;
			imc_out_o <= imc_next;
		end
	end

endmodule

// *** design/io_port_pkg.sv ***
package io_port_pkg;
	localparam int NUM_PORTS = 4;
	localparam int NUM_PINS = 27;
	localparam int IMC_PINS = 24;
	localparam int HOST_ADDR_W = 16;
	// implemented bits per port, three-pin port masked down
	localparam logic [3:0][7:0] PORT_MASK = {8'h07, 8'hff, 8'hff, 8'hff};
	// offsets from the io page base, ordered {d, c, b, a}
	localparam logic [3:0][7:0] OFS_DIN = {8'h11, 8'h10, 8'h01, 8'h00};
	localparam logic [3:0][7:0] OFS_CTL = {8'hff, 8'hff, 8'h03, 8'h02};
	localparam logic [3:0][7:0] OFS_DOUT = {8'h13, 8'h12, 8'h05, 8'h04};
	localparam logic [3:0][7:0] OFS_DIR = {8'h15, 8'h14, 8'h07, 8'h06};
	localparam logic [3:0][7:0] OFS_IMC = {8'hff, 8'h1a, 8'h0b, 8'h0a};
	localparam logic [3:0][7:0] OFS_OMC = {8'h21, 8'h20, 8'h0d, 8'h0c};
	localparam logic [7:0] CTL_PORTS = 8'h02;
	localparam logic [7:0] DOUT_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	typedef enum logic [1:0] {SRC_DOUT, SRC_ADDR, SRC_MACRO, SRC_ECS} out_src_e;
	typedef enum logic [1:0] {IMC_DIRECT, IMC_LATCH, IMC_REG} imc_mode_e;

	// stored per-pin configuration
	typedef struct packed {
		logic la_out;
		logic has_oe;
		out_src_e src;
		imc_mode_e imc_mode;
		logic imc_clk_pt;
	} pin_cfg_s;

	// host bus pins as seen at the device
	typedef struct packed {
		logic sel;
		logic wr_n;
		logic rd_n;
		logic ale;
		logic [HOST_ADDR_W-1:0] addr;
		logic [7:0] data;
	} host_bus_s;
endpackage

// *** verif/host_model.sv ***
`timescale 1ns/10ps
module host_model import io_port_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic [7:0] dq_i,
	output host_bus_s bus_o
);
	initial bus_o = {1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h00};
	task automatic hold(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	// strobe and qualifiers held well past the rising strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus_o.addr = {8'h00, a};
		bus_o.data = d;
		bus_o.sel = 1'b1;
		bus_o.wr_n = 1'b0;
		hold(4);
		bus_o.wr_n = 1'b1;
		hold(4);
		bus_o.sel = 1'b0;
		bus_o.data = ~d; // released bus must not keep the old byte
		hold(4);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		bus_o.addr = {8'h00, a};
		bus_o.sel = 1'b1;
		bus_o.rd_n = 1'b0;
		hold(6);
		d = dq_i;
		bus_o.rd_n = 1'b1;
		bus_o.sel = 1'b0;
		hold(5);
	endtask
	task automatic latch(input logic [15:0] a);
		bus_o.addr = a;
		bus_o.ale = 1'b1;
		hold(4);
		bus_o.ale = 1'b0;
		hold(4);
	endtask
endmodule

// *** verif/io_port_asserts.sv ***
`timescale 1ns/10ps
module io_port_asserts import io_port_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire host_bus_s bus_i,
	input wire logic data_port_i,
	input wire pin_cfg_s [NUM_PINS-1:0] pin_cfg_i,
	input wire logic [NUM_PINS-1:0] pin_in_i,
	input wire logic [NUM_PINS-1:0] pt_oe_i,
	input wire logic [NUM_PINS-1:0] macro_i,
	input wire logic [NUM_PINS-1:0] pin_out_o,
	input wire logic [NUM_PINS-1:0] pin_oe_n_o,
	input wire logic [7:0] rdata_o,
	input wire logic rdata_oe_n_o,
	input wire logic [IMC_PINS-1:0] imc_out_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);
	logic [NUM_PINS-1:0] has_v, la_v, mac_v, dir_v;
	// flatten the per-pin config so one check covers all pins
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			has_v[i] = pin_cfg_i[i].has_oe;
			la_v[i] = pin_cfg_i[i].la_out & ~pin_cfg_i[i].has_oe;
			mac_v[i] = (pin_cfg_i[i].src == SRC_MACRO) && (i >= 16); // no control bits here
			dir_v[i] = pin_cfg_i[i].imc_mode == IMC_DIRECT;
		end
	end
	// host read while port a is not the data bus
	sequence rd_req;
		!bus_i.rd_n && bus_i.sel && !data_port_i;
	endsequence
	sequence rd_off(logic [7:0] o);
		bus_i.addr[7:0] == o && $stable(bus_i.addr) && $stable(pin_in_i);
	endsequence
	reset_idle_a: assert property ($rose(resetn_i) |-> &pin_oe_n_o && pin_out_o == '0)
		else $error("outputs not idle after reset");
	term_oe_a: assert property ($past(resetn_i) && !data_port_i |->
		(pin_oe_n_o & $past(pt_oe_i) & has_v) == '0) else $error("enable term ignored");
	array_out_a: assert property ($past(resetn_i) |-> (pin_oe_n_o & la_v) == '0)
		else $error("array output not driven");
	macro_out_a: assert property ($past(resetn_i) |->
		((pin_out_o ^ $past(macro_i)) & mac_v) == '0) else $error("macrocell not on pin");
	read_drive_a: assert property (rd_req [*5] |-> !rdata_oe_n_o)
		else $error("read data not driven");
	read_release_a: assert property (bus_i.rd_n [*5] |-> rdata_oe_n_o)
		else $error("read data driven while idle");
	data_float_a: assert property ((data_port_i && (bus_i.rd_n || !bus_i.sel)) [*5]
		|-> &pin_oe_n_o[7:0]) else $error("data port driven while idle");
	din_read_a: assert property (rd_off(OFS_DIN[2]) [*6] |-> rdata_o == pin_in_i[23:16])
		else $error("data-in read wrong");
	imc_direct_a: assert property ($stable(pin_in_i) [*6] |->
		((imc_out_o ^ pin_in_i[23:0]) & dir_v[23:0]) == '0) else $error("direct input wrong");
endmodule
bind io_port_block io_port_asserts chk_u (.*);

// *** verif/tb_io_port_block.sv ***
`timescale 1ns/10ps
module tb_io_port_block import io_port_pkg::*;;
	logic ref_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic data_port_i = 1'b0;
	pin_cfg_s [NUM_PINS-1:0] cfg = '0;
	logic [NUM_PINS-1:0] pin_in = 27'h0563412;
	logic [NUM_PINS-1:0] pt_oe = '0;
	logic [NUM_PINS-1:0] macro = 27'h00a0000;
	logic [NUM_PINS-1:0] pin_out, oe_n;
	logic [5:0] imc_pt = 6'h00;
	logic [2:0] ecs = 3'h0;
	logic [7:0] rdata, d;
	logic rd_oe_n;
	logic [IMC_PINS-1:0] imc_out;
	host_bus_s bus;
	int err_count = 0;
	int total_checks = 0;
	// offset, byte written, byte read back
	logic [23:0] rows [6] = '{{OFS_DOUT[0], 8'ha5, 8'ha5}, {OFS_DIR[0], 8'h3c, 8'h3c},
		{OFS_CTL[1], 8'h81, 8'h81}, {OFS_DIR[3], 8'hff, 8'h07},
		{OFS_DOUT[3], 8'hff, 8'h07}, {8'h30, 8'h55, UNMAPPED_READ}};
	always #10 ref_clk_i = ~ref_clk_i;
	io_port_block #(.PIN_COUNT(NUM_PINS)) dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
		.bus_i(bus), .data_port_i(data_port_i), .pin_cfg_i(cfg), .pin_in_i(pin_in),
		.pt_oe_i(pt_oe), .macro_i(macro), .ecs_i(ecs), .imc_pt_i(imc_pt),
		.pin_out_o(pin_out), .pin_oe_n_o(oe_n), .rdata_o(rdata), .rdata_oe_n_o(rd_oe_n),
		.imc_out_o(imc_out));
	host_model host_u (.ref_clk_i(ref_clk_i), .dq_i(data_port_i ? pin_out[7:0] : rdata),
		.bus_o(bus));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		#100us;
		err_count++;
		results();
	end
	// static pin setup, then reset, table, and hand cases
	initial begin
		for (int i = 16; i < 20; i++) cfg[i].src = SRC_MACRO;
		for (int i = 24; i < 27; i++) cfg[i].src = SRC_ECS;
		cfg[20].has_oe = 1'b1;
		cfg[21].la_out = 1'b1;
		cfg[8].imc_mode = IMC_LATCH;
		cfg[8].imc_clk_pt = 1'b1;
		cfg[10].imc_mode = IMC_REG;
		repeat (8) @(negedge ref_clk_i);
		check("oe_n rst", oe_n, 27'h7ffffff);
		resetn_i = 1'b1;
		@(negedge ref_clk_i);
		// pin 21 is an array output without enable term, so it drives at once
		check("oe_n", oe_n, 27'h7dfffff);
		check("rd_oe_n", rd_oe_n, 1'b1);
		foreach (rows[i]) begin
			macro[23:16] = rows[i][15:8];
			ecs = rows[i][10:8];
			host_u.wr(rows[i][23:16], rows[i][15:8]);
			host_u.rd(rows[i][23:16], d);
			check("readback", d, rows[i][7:0]);
			check("port c macro", pin_out[19:16], macro[19:16]);
			check("ecs row", pin_out[26:24], ecs);
		end
		check("port a out", pin_out[7:0], 8'ha5);
		check("port a oe_n", oe_n[7:0], 8'hc3);
		check("port d ecs", pin_out[26:24], 3'b101);
		pt_oe[20] = 1'b1;
		host_u.latch(16'h0080);
		check("port b addr", pin_out[15:8], 8'h80);
		check("c enables", oe_n[22:20], 3'b100);
		for (int i = 0; i < 3; i++) begin
			host_u.rd(OFS_DIN[i], d);
			check("din", d, pin_in[8*i +: 8]);
		end
		host_u.rd(OFS_OMC[2], d);
		check("macro rb", d, macro[23:16]);
		pin_in[8] = 1'b1;
		host_u.hold(4);
		imc_pt[2] = 1'b1;
		host_u.hold(3);
		imc_pt[2] = 1'b0;
		host_u.hold(2);
		pin_in[8] = 1'b0;
		pin_in[10] = 1'b0;
		host_u.hold(6);
		check("imc latch", imc_out[8], 1'b1);
		check("imc reg", imc_out[10], 1'b1);
		data_port_i = 1'b1;
		host_u.hold(6);
		check("data port idle", oe_n[7:0], 8'hff);
		host_u.rd(OFS_DOUT[0], d);
		check("data port read", d, 8'ha5);
		// in data port mode the written byte comes from the port a pins
		pin_in[7:0] = 8'h5a;
		host_u.wr(OFS_DOUT[1], 8'h00);
		host_u.rd(OFS_DOUT[1], d);
		check("data port write", d, 8'h5a);
		// mid-run reset must clear the registers written above
		resetn_i = 1'b0;
		host_u.hold(4);
		check("oe_n mid rst", oe_n, 27'h7ffffff);
		resetn_i = 1'b1;
		host_u.hold(1);
		host_u.rd(OFS_CTL[1], d);
		check("ctl after rst", d, 8'h00);
		host_u.rd(OFS_DOUT[1], d);
		check("dout after rst", d, 8'h00);
		check("port b after rst", pin_out[15:8], 8'h00);
		results();
	end
endmodule
